// ==== pfs_supervisor.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pfs_consts.vh"

module pfs_supervisor #(
  parameter [21:0] TLIM_CYC = `PFS_TLIM_CYC,
  parameter [21:0] TOUT_CYC = `PFS_TOUT_CYC,
  parameter [21:0] RDLY_CYC = `PFS_RDLY_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ov_rise_threshold_i,
  input wire ov_fall_threshold_i,
  input wire uv_fall_threshold_i,
  input wire uv_rise_threshold_i,
  input wire peak_current_limit_i,
  input wire short_circuit_i,
  input wire thermal_trip_threshold_i,
  input wire soft_start_done_i,
  input wire shutdown_n_i,
  input wire standby_n_i,
  input wire [3:0] select_a_i,
  output reg power_good_n_o,
  output reg power_good_oe_o,
  output reg converter_en_o,
  output reg soft_start_o,
  output reg current_limit_o,
  output reg termination_output_en_o,
  output reg reference_en_o,
  output reg discharge_o,
  output reg [9:0] select_a_khz_o,
  output reg irq_o
);

  // ==========================================================
  // state encoding
  localparam [7:0] ST_OFF = 8'h01;
  localparam [7:0] ST_STANDBY_N = 8'h02;
  localparam [7:0] ST_SSTART = 8'h04;
  localparam [7:0] ST_DELAY = 8'h08;
  localparam [7:0] ST_RUN = 8'h10;
  localparam [7:0] ST_LIMIT = 8'h20;
  localparam [7:0] ST_HOT = 8'h40;
  localparam [7:0] ST_RETRY = 8'h80;
  localparam integer FILT_INT = `PFS_FILT_CYC;
  localparam [9:0] FILT_CYC = FILT_INT[9:0];

  // ==========================================================
  // input synchronisers: every pin but the wishbone bus passes two flops first
  reg [13:0] sync1_r;
  reg [13:0] sync2_r;
  wire [13:0] pins = {select_a_i, standby_n_i, shutdown_n_i, soft_start_done_i,
    thermal_trip_threshold_i, short_circuit_i, peak_current_limit_i,
    uv_rise_threshold_i, uv_fall_threshold_i, ov_fall_threshold_i, ov_rise_threshold_i};

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 14'h0000;
      sync2_r <= 14'h0000;
    end
    else
    begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  wire ov_hi = sync2_r[0];
  wire ov_rel = sync2_r[1];
  wire uv_lo = sync2_r[2];
  wire uv_rel = sync2_r[3];
  wire ilim = sync2_r[4];
  wire short_s = sync2_r[5];
  wire hot = sync2_r[6];
  wire ss_done = sync2_r[7];
  wire sd_n = sync2_r[8];
  wire sb_n = sync2_r[9];
  wire [3:0] sel_code = sync2_r[13:10];

  // ==========================================================
  // voltage fault filters, channel 0 overvoltage, channel 1 undervoltage
  wire [1:0] trip_in = {uv_lo, ov_hi};
  wire [1:0] rel_in = {uv_rel, ov_rel};
  wire [1:0] qual;
  reg [1:0] fault_r;
  reg [1:0] fault_nxt;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_filt
      reg [9:0] fcnt_r;
      always @(posedge clk_i)
      begin
        if (rst_i || !trip_in[g])
          fcnt_r <= 10'h000;
        else if (fcnt_r != FILT_CYC)
          fcnt_r <= fcnt_r + 10'h001;
      end
      assign qual[g] = (fcnt_r == FILT_CYC);
    end
  endgenerate

  always @*
  begin
    fault_nxt = (fault_r & ~rel_in) | qual;
  end

  // ==========================================================
  // sequencer
  reg [7:0] state_r;
  reg [7:0] state_nxt;
  reg [21:0] cnt_r;
  reg [3:0] code_r;
  reg [3:0] code_nxt;
  wire conv_on = state_r == ST_SSTART || state_r == ST_DELAY ||
    state_r == ST_RUN || state_r == ST_LIMIT;

  always @*
  begin
    state_nxt = state_r;
    code_nxt = code_r;
    case (state_r)
      ST_OFF:
      begin
        // host enable starts a soft start
        if (sd_n && sb_n)
        begin
          state_nxt = ST_SSTART;
          code_nxt = sel_code;
        end
        else if (sd_n)
          state_nxt = ST_STANDBY_N;
      end
      ST_STANDBY_N:
      begin
        if (!sd_n)
          state_nxt = ST_OFF;
        else if (sb_n)
        begin
          state_nxt = ST_SSTART;
          code_nxt = sel_code;
        end
      end
      ST_HOT:
      begin
        // hold off until the hysteretic flag clears
        if (!hot)
          state_nxt = ST_RETRY;
      end
      ST_RETRY:
      begin
        if (cnt_r >= TOUT_CYC - 22'h000001)
          state_nxt = ST_SSTART;
      end
      ST_SSTART:
      begin
        if (ss_done)
          state_nxt = ST_DELAY;
      end
      ST_DELAY:
      begin
        if (cnt_r >= RDLY_CYC - 22'h000001)
          state_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        if (ilim)
          state_nxt = ST_LIMIT;
      end
      ST_LIMIT:
      begin
        if (!ilim)
          state_nxt = ST_RUN;
        else if (cnt_r >= TLIM_CYC - 22'h000001)
          state_nxt = ST_RETRY;
      end
      default:
        state_nxt = ST_OFF;
    endcase
    // short and thermal outrank the per-state moves above
    if (state_r != ST_OFF && state_r != ST_STANDBY_N)
    begin
      if (hot)
        state_nxt = ST_HOT;
      // short circuit turns off at once, no limit timer
      else if (short_s && conv_on)
        state_nxt = ST_RETRY;
    end
    // host controls win over everything
    if (!sd_n)
      state_nxt = ST_OFF;
    else if (!sb_n)
      state_nxt = ST_STANDBY_N;
  end

  // sixteen equal bands, top band is 200 kHz, ground is 1000 kHz
  function [9:0] select_a_of;
    input [3:0] c;
    begin
      case (c)
        4'hf: select_a_of = 10'h0c8;
        4'he: select_a_of = 10'h0fd;
        4'hd: select_a_of = 10'h133;
        4'hc: select_a_of = 10'h168;
        4'hb: select_a_of = 10'h19d;
        4'ha: select_a_of = 10'h1d2;
        4'h9: select_a_of = 10'h208;
        4'h8: select_a_of = 10'h23d;
        4'h7: select_a_of = 10'h273;
        4'h6: select_a_of = 10'h2a8;
        4'h5: select_a_of = 10'h2dd;
        4'h4: select_a_of = 10'h313;
        4'h3: select_a_of = 10'h348;
        4'h2: select_a_of = 10'h37d;
        4'h1: select_a_of = 10'h3b3;
        default: select_a_of = 10'h3e8;
      endcase
    end
  endfunction

  // power good only in regulation and with no voltage fault pending
  wire pg_good_nxt = (state_nxt == ST_RUN || state_nxt == ST_LIMIT) && (fault_nxt == 2'b00);

  // ==========================================================
  // interrupt events
  reg [5:0] irq_stat_r;
  reg [5:0] irq_en_r;
  reg [5:0] ev;
  always @*
  begin
    ev = 6'h00;
    ev[`PFS_EV_OV] = fault_nxt[0] && !fault_r[0];
    ev[`PFS_EV_UV] = fault_nxt[1] && !fault_r[1];
    // a short while limiting is a short-circuit shutdown, not a timer expiry
    ev[`PFS_EV_OC] = state_r == ST_LIMIT && state_nxt == ST_RETRY && !short_s;
    ev[`PFS_EV_SC] = conv_on && state_nxt == ST_RETRY && short_s;
    ev[`PFS_EV_OT] = state_nxt == ST_HOT && state_r != ST_HOT;
    ev[`PFS_EV_PG] = pg_good_nxt && power_good_n_o;
  end

  // ==========================================================
  // wishbone slave, one wait state: ack one cycle after the strobe
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_clr = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PFS_ADR_IRQ_CLEAR;
  wire wr_en = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PFS_ADR_IRQ_ENABLE;
  wire [5:0] clr_mask = wr_clr ? wb_dat_i[5:0] : 6'h00;
  wire [5:0] irq_stat_nxt = (irq_stat_r & ~clr_mask) | ev;
  wire [5:0] irq_en_nxt = wr_en ? wb_dat_i[5:0] : irq_en_r;
  reg [31:0] rd_data;
  always @*
  begin
    rd_data = 32'h00000000;
    case (wb_adr_i)
      `PFS_ADR_STATUS:
      begin
        rd_data[`PFS_ST_STATE_LSB +: 8] = state_r;
        rd_data[`PFS_ST_OV] = fault_r[0];
        rd_data[`PFS_ST_UV] = fault_r[1];
        rd_data[`PFS_ST_PG] = !power_good_n_o;
        rd_data[`PFS_ST_CODE_LSB +: 4] = code_r;
        rd_data[`PFS_ST_SELECT_A_LSB +: 10] = select_a_khz_o;
      end
      `PFS_ADR_IRQ_STATUS: rd_data[5:0] = irq_stat_r;
      `PFS_ADR_IRQ_ENABLE: rd_data[5:0] = irq_en_r;
      default: rd_data = 32'h00000000;
    endcase
  end

  // ==========================================================
  // registers and outputs
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_OFF;
      cnt_r <= 22'h000000;
      code_r <= `PFS_CODE_RST;
      fault_r <= 2'b00;
      irq_stat_r <= 6'h00;
      irq_en_r <= `PFS_IRQ_EN_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      power_good_n_o <= 1'b1;
      power_good_oe_o <= 1'b0;
      converter_en_o <= 1'b0;
      soft_start_o <= 1'b0;
      current_limit_o <= 1'b0;
      termination_output_en_o <= 1'b0;
      reference_en_o <= 1'b0;
      discharge_o <= 1'b1;
      select_a_khz_o <= 10'h3e8;
      irq_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r) ? 22'h000000 : cnt_r + 22'h000001;
      code_r <= code_nxt;
      fault_r <= fault_nxt;
      // set wins over clear for events in the clearing cycle
      irq_stat_r <= irq_stat_nxt;
      irq_en_r <= irq_en_nxt;
      irq_o <= |(irq_stat_nxt & irq_en_nxt);
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h00000000;
      // power good returns once a retry reaches regulation
      power_good_n_o <= !pg_good_nxt;
      power_good_oe_o <= pg_good_nxt;
      soft_start_o <= state_nxt == ST_SSTART && state_r != ST_SSTART;
      converter_en_o <= state_nxt == ST_SSTART || state_nxt == ST_DELAY ||
        state_nxt == ST_RUN || state_nxt == ST_LIMIT;
      current_limit_o <= state_nxt == ST_LIMIT;
      // standby floats termination, reference stays active
      termination_output_en_o <= state_nxt == ST_SSTART || state_nxt == ST_DELAY ||
        state_nxt == ST_RUN || state_nxt == ST_LIMIT;
      reference_en_o <= state_nxt != ST_OFF;
      discharge_o <= state_nxt == ST_OFF;
      select_a_khz_o <= select_a_of(code_nxt);
    end
  end

endmodule
`default_nettype wire

// ==== pfs_consts.vh ====
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH

// ==========================================================
// clock and timing
`define PFS_CLK_KHZ 25000
`define PFS_FILT_US 20
`define PFS_FILT_CYC ((`PFS_FILT_US * `PFS_CLK_KHZ + 999) / 1000)
`define PFS_TLIM_MS 10
`define PFS_TLIM_CYC (`PFS_TLIM_MS * `PFS_CLK_KHZ)
`define PFS_TOUT_MS 100
`define PFS_TOUT_CYC (`PFS_TOUT_MS * `PFS_CLK_KHZ)
`define PFS_RDLY_MS 10
`define PFS_RDLY_CYC (`PFS_RDLY_MS * `PFS_CLK_KHZ)

// ==========================================================
// register byte offsets
`define PFS_ADR_STATUS 8'h00
`define PFS_ADR_IRQ_STATUS 8'h04
`define PFS_ADR_IRQ_CLEAR 8'h08
`define PFS_ADR_IRQ_ENABLE 8'h0c

// ==========================================================
// interrupt event bit positions
`define PFS_EV_OV 0
`define PFS_EV_UV 1
`define PFS_EV_OC 2
`define PFS_EV_SC 3
`define PFS_EV_OT 4
`define PFS_EV_PG 5
`define PFS_EV_W 6

// ==========================================================
// status register fields and reset values
`define PFS_ST_STATE_LSB 0
`define PFS_ST_OV 8
`define PFS_ST_UV 9
`define PFS_ST_PG 10
`define PFS_ST_CODE_LSB 12
`define PFS_ST_SELECT_A_LSB 16
`define PFS_IRQ_EN_RST 6'h00
`define PFS_CODE_RST 4'h0

`endif

// ==== pfs_supervisor_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// fault supervisor checker
module pfs_supervisor_monitor #(
  parameter [21:0] TLIM_CYC = 22'h000014,
  parameter [21:0] RDLY_CYC = 22'h000014
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ov_rise_threshold_i,
  input wire logic uv_fall_threshold_i,
  input wire logic short_circuit_i,
  input wire logic thermal_trip_threshold_i,
  input wire logic shutdown_n_i,
  input wire logic standby_n_i,
  input wire logic power_good_n_o,
  input wire logic converter_en_o,
  input wire logic current_limit_o,
  input wire logic termination_output_en_o,
  input wire logic reference_en_o,
  input wire logic discharge_o
);
  logic [15:0] ov_cnt_r;
  logic [15:0] uv_cnt_r;
  logic [21:0] lim_cnt_r;
  logic [21:0] on_cnt_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // run lengths of raw flags and of outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ov_cnt_r <= 16'h0000;
      uv_cnt_r <= 16'h0000;
      lim_cnt_r <= 22'h000000;
      on_cnt_r <= 22'h000000;
    end
    else
    begin
      ov_cnt_r <= ov_rise_threshold_i ? ov_cnt_r + 16'h0001 : 16'h0000;
      uv_cnt_r <= uv_fall_threshold_i ? uv_cnt_r + 16'h0001 : 16'h0000;
      lim_cnt_r <= current_limit_o ? lim_cnt_r + 22'h000001 : 22'h000000;
      on_cnt_r <= converter_en_o ? on_cnt_r + 22'h000001 : 22'h000000;
    end
  end
  // ==========================================
  // properties
  sequence s_hot_held;
    thermal_trip_threshold_i [*6];
  endsequence
  sequence s_off_report;
    !converter_en_o && power_good_n_o;
  endsequence
  property p_ov_report;
    ov_cnt_r > 16'h01fb |-> power_good_n_o;
  endproperty
  // margin of a few cycles covers the input synchronisers
  property p_pg_rise;
    $rose(power_good_n_o) && converter_en_o && !current_limit_o
      |-> ov_cnt_r > 16'h01f3 || uv_cnt_r > 16'h01f3;
  endproperty
  property p_lim_bound;
    lim_cnt_r <= TLIM_CYC + 22'h000002;
  endproperty
  property p_short_off;
    $rose(short_circuit_i) && converter_en_o |-> ##[1:5] s_off_report;
  endproperty
  property p_hot_off;
    s_hot_held |-> s_off_report;
  endproperty
  property p_sd_off;
    !shutdown_n_i [*6] |-> discharge_o && !reference_en_o && !converter_en_o;
  endproperty
  property p_standby_n;
    (!standby_n_i && shutdown_n_i) [*6] |-> !termination_output_en_o && reference_en_o;
  endproperty
  property p_pg_delay;
    $fell(power_good_n_o) |-> on_cnt_r >= RDLY_CYC;
  endproperty
  a_ov_report: assert property (p_ov_report)
    else $error("overvoltage not reported");
  a_pg_rise: assert property (p_pg_rise)
    else $error("power good released without filtered flag");
  a_lim_bound: assert property (p_lim_bound)
    else $error("limiting outlasted timer");
  a_short_off: assert property (p_short_off)
    else $error("short circuit did not switch off");
  a_hot_off: assert property (p_hot_off)
    else $error("hot device still switching");
  a_sd_off: assert property (p_sd_off)
    else $error("shutdown not discharging");
  a_standby_n: assert property (p_standby_n)
    else $error("standby outputs wrong");
  a_pg_delay: assert property (p_pg_delay)
    else $error("power good before delay");
endmodule
`default_nettype wire

// ==== pfs_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host: enables plus pulled-up power good line
module pfs_host_model (
  input wire logic clk_i,
  input wire logic [1:0] cmd_i,
  input wire logic power_good_oe_i,
  output var logic shutdown_n_o = 1'b0,
  output var logic standby_n_o = 1'b0,
  output var logic pg_line_o
);
  // host enables
  // cmd 0 shutdown, 1 standby, 2 run
  always @(posedge clk_i)
  begin
    shutdown_n_o <= cmd_i != 2'h0;
    standby_n_o <= cmd_i == 2'h2;
  end
  // external pull-up wins when nobody sinks
  assign pg_line_o = power_good_oe_i ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ==== power_fault_supervisor_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench
module power_fault_supervisor_test;
  localparam [21:0] CYC = 22'h000014;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic ov_rise_threshold_i = 1'b0, ov_fall_threshold_i = 1'b1, uv_fall_threshold_i = 1'b0;
  logic uv_rise_threshold_i = 1'b1, peak_current_limit_i = 1'b0, short_circuit_i = 1'b0;
  logic thermal_trip_threshold_i = 1'b0, soft_start_done_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf, select_a_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [1:0] cmd = 2'h0;
  logic [9:0] select_a_khz_o;
  logic wb_ack_o, power_good_n_o, power_good_oe_o, converter_en_o, soft_start_o;
  logic current_limit_o, termination_output_en_o, reference_en_o, discharge_o, irq_o;
  logic shutdown_n_i, standby_n_i, pg_line;
  int bad_count = 0, comparisons = 0, ticks = 0;
  logic [9:0] ftab [16] = '{10'h3e8, 10'h3b3, 10'h37d, 10'h348, 10'h313, 10'h2dd,
    10'h2a8, 10'h273, 10'h23d, 10'h208, 10'h1d2, 10'h19d, 10'h168, 10'h133, 10'h0fd, 10'h0c8};
  pfs_supervisor #(.TLIM_CYC(CYC), .TOUT_CYC(CYC), .RDLY_CYC(CYC)) i_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .ov_rise_threshold_i, .ov_fall_threshold_i, .uv_fall_threshold_i,
    .uv_rise_threshold_i, .peak_current_limit_i, .short_circuit_i, .thermal_trip_threshold_i,
    .soft_start_done_i, .shutdown_n_i, .standby_n_i, .select_a_i, .power_good_n_o,
    .power_good_oe_o, .converter_en_o, .soft_start_o, .current_limit_o,
    .termination_output_en_o, .reference_en_o, .discharge_o, .select_a_khz_o, .irq_o);
  pfs_host_model i_host (.clk_i, .cmd_i(cmd), .power_good_oe_i(power_good_oe_o),
    .shutdown_n_o(shutdown_n_i), .standby_n_o(standby_n_i), .pg_line_o(pg_line));
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    ticks <= ticks + 1;
    if (ticks == 10000)
    begin
      bad_count++;
      final_report;
    end
  end
  // ==========================================
  // shared tasks
  task automatic final_report;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic until_pg(input logic v);
    while (power_good_n_o !== v) @(posedge clk_i);
  endtask
  task automatic wait_ss;
    while (soft_start_o !== 1'b1) @(posedge clk_i);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    tick(2);
  endtask
  // ==========================================
  // scenarios
  task automatic t_start(input logic [3:0] code);
    cmd <= 2'h0;
    select_a_i <= code;
    soft_start_done_i <= 1'b0;
    tick(8);
    chk(discharge_o, 1'b1);
    cmd <= 2'h2;
    wait_ss;
    soft_start_done_i <= 1'b1;
    // two sync flops, one edge into delay, the delay count, one edge to the pin
    tick(int'(CYC) + 3);
    chk(power_good_n_o, 1'b1);
    tick(1);
    chk(power_good_n_o, 1'b0);
    until_pg(1'b0);
    chk({pg_line, select_a_khz_o}, {1'b0, ftab[code]});
  endtask
  task automatic t_volt(input logic uv);
    ov_rise_threshold_i <= !uv;
    uv_fall_threshold_i <= uv;
    ov_fall_threshold_i <= uv;
    uv_rise_threshold_i <= !uv;
    tick(400);
    {ov_rise_threshold_i, uv_fall_threshold_i} <= 2'h0;
    tick(4);
    chk(power_good_n_o, 1'b0);
    ov_rise_threshold_i <= !uv;
    uv_fall_threshold_i <= uv;
    tick(510);
    chk({power_good_n_o, converter_en_o, termination_output_en_o}, 3'h7);
    {ov_rise_threshold_i, uv_fall_threshold_i} <= 2'h0;
    {ov_fall_threshold_i, uv_rise_threshold_i} <= 2'h3;
    tick(6);
    chk(power_good_n_o, 1'b0);
  endtask
  task automatic t_oc;
    peak_current_limit_i <= 1'b1;
    tick(8);
    chk(current_limit_o, 1'b1);
    peak_current_limit_i <= 1'b0;
    tick(8);
    chk({current_limit_o, converter_en_o, power_good_n_o}, 3'h2);
    peak_current_limit_i <= 1'b1;
    tick(30);
    chk({converter_en_o, power_good_n_o}, 2'h1);
    peak_current_limit_i <= 1'b0;
    wait_ss;
    until_pg(1'b0);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd[2], 1'b1);
  endtask
  task automatic t_off(input logic hot);
    // clear short and thermal events left by an earlier run
    wb(1'b1, 8'h08, 32'h18);
    peak_current_limit_i <= 1'b1;
    tick(6);
    short_circuit_i <= !hot;
    thermal_trip_threshold_i <= hot;
    tick(hot ? 40 : 6);
    chk({converter_en_o, current_limit_o, power_good_n_o}, 3'h1);
    {short_circuit_i, thermal_trip_threshold_i, peak_current_limit_i} <= 3'h0;
    wait_ss;
    until_pg(1'b0);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd[4:3], hot ? 2'h2 : 2'h1);
  endtask
  task automatic t_irq;
    // run state, power good, code 15 latched, 200 kHz
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00c8f410);
    wb(1'b1, 8'h0c, 32'h3f);
    chk(irq_o, 1'b1);
    wb(1'b1, 8'h0c, 32'h0);
    chk(irq_o, 1'b0);
    wb(1'b1, 8'h0c, 32'h3f);
    wb(1'b1, 8'h08, 32'h3f);
    chk(irq_o, 1'b0);
    wb(1'b1, 8'h40, 32'h1);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_standby_n;
    cmd <= 2'h1;
    tick(8);
    chk({termination_output_en_o, reference_en_o, discharge_o}, 3'h2);
    cmd <= 2'h0;
    tick(8);
    chk({converter_en_o, reference_en_o, discharge_o, pg_line}, 4'h3);
  endtask
  initial
  begin
    tick(5);
    rst_i <= 1'b0;
    tick(2);
    chk({power_good_n_o, discharge_o, select_a_khz_o}, {2'h3, 10'h3e8});
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 16; i++) t_start(i[3:0]);
    t_volt(1'b0);
    t_volt(1'b1);
    t_oc;
    t_off(1'b0);
    t_off(1'b1);
    t_irq;
    t_standby_n;
    final_report;
  end
endmodule
bind pfs_supervisor pfs_supervisor_monitor #(.TLIM_CYC(TLIM_CYC), .RDLY_CYC(RDLY_CYC)) i_mon (
  .clk_i, .rst_i, .ov_rise_threshold_i, .uv_fall_threshold_i, .short_circuit_i,
  .thermal_trip_threshold_i, .shutdown_n_i, .standby_n_i, .power_good_n_o, .converter_en_o,
  .current_limit_o, .termination_output_en_o, .reference_en_o, .discharge_o);
`default_nettype wire
